// >>> rtl/admc_regs.svh
/*
 * constants of the analog die mode controller: clock rate and timing counts.
 * assumes the including file defines nothing with the same names.
 */
`ifndef ADMC_REGS_SVH
`define ADMC_REGS_SVH
`define ADMC_CLK_MHZ 200
`define ADMC_WINDOW_MS 80
`define ADMC_WINDOW_CYC (`ADMC_WINDOW_MS * 1000 * `ADMC_CLK_MHZ)
`define ADMC_RESET_HOLD_CYC 16
`define ADMC_IRQ_PULSE_CYC 16
`endif

// >>> rtl/admc_pkg.sv
/*
 * types of the analog die mode controller.
 * assumes the constants header is included by the modules.
 */
package admc_pkg;
  typedef enum logic [2:0] {
    ADMC_RESET = 3'b000,
    ADMC_NORM_REQ = 3'b001,
    ADMC_NORMAL = 3'b010,
    ADMC_STOP = 3'b011,
    ADMC_SLEEP = 3'b100
  } admc_mode_t;
endpackage

// >>> rtl/admc_sync.sv
/*
 * two flip-flop synchroniser for one asynchronous level.
 * assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module admc_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

// >>> rtl/admc_mode_ctrl.sv
/*
 * operating mode controller of the analog die: reset, normal request,
 * normal, stop and sleep, with the power-on supervision deadline.
 * assumes control bits come from the spi register logic on clk and
 * that wake, bus and test levels are asynchronous pins.
 */
`timescale 1ns/1ps
`include "admc_regs.svh"
module admc_mode_ctrl #(
  parameter int unsigned WINDOW_CYC = `ADMC_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stop_bit,
  input wire logic sleep_bit,
  input wire logic power_stage_on_bit,
  input wire logic bus_wake_irq_enable,
  input wire logic wake_input_irq_enable,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic watchdog_bad_service,
  input wire logic flag_clear_wake_input,
  input wire logic flag_clear_bus_wake,
  input wire logic reset_flags_clear,
  input wire logic wake_up_input,
  input wire logic bus_wake_event,
  input wire logic factory_test_input,
  output logic [2:0] mode,
  output logic spi_regs_reset,
  output logic irq_enables_clear,
  output logic reset_line_o,
  output logic reset_line_oe,
  output logic irq_line_o,
  output logic irq_line_oe,
  output logic logic_supply_on,
  output logic supply_limited,
  output logic power_stages_enable,
  output logic bus_tx_enable,
  output logic bus_rx_enable,
  output logic watchdog_run,
  output logic wake_input_flag,
  output logic bus_wake_flag,
  output logic wake_input_wake_flag,
  output logic bus_wake_reset_flag,
  output logic watchdog_reset_flag
);
  admc_pkg::admc_mode_t st_r;
  admc_pkg::admc_mode_t st_nxt;
  logic [31:0] win_r;
  logic [31:0] win_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic [7:0] irq_r;
  logic [7:0] irq_nxt;
  logic wake_s;
  logic bus_s;
  logic test_s;
  logic wake_d_r;
  logic bus_d_r;
  logic wake_edge;
  logic bus_edge;
  logic wif_r;
  logic wif_nxt;
  logic bif_r;
  logic bif_nxt;
  logic wwf_r;
  logic wwf_nxt;
  logic bwf_r;
  logic bwf_nxt;
  logic wdf_r;
  logic wdf_nxt;
  logic wd_rst;
  logic stop_wake_w;
  logic stop_wake_b;
  logic sleep_wake;

  admc_sync u_sync_wake (.clk(clk), .arst_n(arst_n), .async_in(wake_up_input),
    .sync_out(wake_s));
  admc_sync u_sync_bus (.clk(clk), .arst_n(arst_n), .async_in(bus_wake_event),
    .sync_out(bus_s));
  admc_sync u_sync_test (.clk(clk), .arst_n(arst_n), .async_in(factory_test_input),
    .sync_out(test_s));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_d_r <= 1'b0;
      bus_d_r <= 1'b0;
    end else begin
      wake_d_r <= wake_s;
      bus_d_r <= bus_s;
    end
  end

  // either edge on the wake input; rising edge of the qualified bus event
  assign wake_edge = wake_s ^ wake_d_r;
  assign bus_edge = bus_s & ~bus_d_r & ~test_s;

  assign wd_rst = watchdog_run & (watchdog_timeout | watchdog_bad_service);
  assign stop_wake_w = (st_r == admc_pkg::ADMC_STOP) & wake_edge & wake_input_irq_enable;
  assign stop_wake_b = (st_r == admc_pkg::ADMC_STOP) & bus_edge & bus_wake_irq_enable;
  assign sleep_wake = (st_r == admc_pkg::ADMC_SLEEP) & (wake_edge | bus_edge);

  always_comb begin
    st_nxt = st_r;
    win_nxt = win_r;
    hold_nxt = hold_r;
    irq_nxt = (irq_r != 8'h00) ? irq_r - 8'h01 : 8'h00;
    unique case (st_r)
      admc_pkg::ADMC_RESET: begin
        if (hold_r == 8'h00) begin
          st_nxt = admc_pkg::ADMC_NORM_REQ;
          win_nxt = 32'h0000_0000;
        end else begin
          hold_nxt = hold_r - 8'h01;
        end
      end
      admc_pkg::ADMC_NORM_REQ: begin
        if (power_stage_on_bit) begin
          st_nxt = admc_pkg::ADMC_NORMAL;
        end else if (!test_s) begin
          if (win_r >= WINDOW_CYC - 1) begin
            st_nxt = admc_pkg::ADMC_SLEEP;
          end else begin
            win_nxt = win_r + 32'h0000_0001;
          end
        end
      end
      admc_pkg::ADMC_NORMAL: begin
        if (sleep_bit) begin
          st_nxt = admc_pkg::ADMC_SLEEP;
        end else if (stop_bit) begin
          st_nxt = admc_pkg::ADMC_STOP;
        end
      end
      admc_pkg::ADMC_STOP: begin
        if (stop_wake_w | stop_wake_b) begin
          irq_nxt = 8'(`ADMC_IRQ_PULSE_CYC);
          st_nxt = admc_pkg::ADMC_NORMAL;
        end else if (sleep_bit) begin
          st_nxt = admc_pkg::ADMC_SLEEP;
        end
      end
      admc_pkg::ADMC_SLEEP: begin
        if (sleep_wake) begin
          st_nxt = admc_pkg::ADMC_RESET;
          hold_nxt = 8'(`ADMC_RESET_HOLD_CYC);
        end
      end
      default: begin
        st_nxt = admc_pkg::ADMC_RESET;
        hold_nxt = 8'(`ADMC_RESET_HOLD_CYC);
      end
    endcase
    if (wd_rst) begin
      st_nxt = admc_pkg::ADMC_RESET;
      hold_nxt = 8'(`ADMC_RESET_HOLD_CYC);
    end
  end

  // flags: set wins over clear
  always_comb begin
    wif_nxt = stop_wake_w | (wif_r & ~flag_clear_wake_input);
    bif_nxt = stop_wake_b | (bif_r & ~flag_clear_bus_wake);
    wwf_nxt = (sleep_wake & wake_edge) | (wwf_r & ~reset_flags_clear);
    bwf_nxt = (sleep_wake & bus_edge) | (bwf_r & ~reset_flags_clear);
    wdf_nxt = wd_rst | (wdf_r & ~reset_flags_clear);
    if (st_r == admc_pkg::ADMC_RESET) begin
      wif_nxt = 1'b0;
      bif_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= admc_pkg::ADMC_RESET;
      win_r <= 32'h0000_0000;
      hold_r <= 8'(`ADMC_RESET_HOLD_CYC);
      irq_r <= 8'h00;
      wif_r <= 1'b0;
      bif_r <= 1'b0;
      wwf_r <= 1'b0;
      bwf_r <= 1'b0;
      wdf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      win_r <= win_nxt;
      hold_r <= hold_nxt;
      irq_r <= irq_nxt;
      wif_r <= wif_nxt;
      bif_r <= bif_nxt;
      wwf_r <= wwf_nxt;
      bwf_r <= bwf_nxt;
      wdf_r <= wdf_nxt;
    end
  end

  assign mode = st_r;
  assign spi_regs_reset = (st_r == admc_pkg::ADMC_RESET);
  assign irq_enables_clear = (st_r == admc_pkg::ADMC_RESET);
  // reset low in reset and sleep
  assign reset_line_o = 1'b0;
  assign reset_line_oe = (st_r == admc_pkg::ADMC_RESET) | (st_r == admc_pkg::ADMC_SLEEP);
  assign irq_line_o = 1'b0;
  assign irq_line_oe = (irq_r != 8'h00);
  assign logic_supply_on = (st_r != admc_pkg::ADMC_SLEEP);
  assign supply_limited = (st_r == admc_pkg::ADMC_STOP);
  assign power_stages_enable = (st_r == admc_pkg::ADMC_NORMAL);
  assign bus_tx_enable = (st_r == admc_pkg::ADMC_NORMAL);
  assign bus_rx_enable = ~test_s & (st_r != admc_pkg::ADMC_RESET) &
    (st_r != admc_pkg::ADMC_NORM_REQ);
  assign watchdog_run = (st_r == admc_pkg::ADMC_NORMAL) & watchdog_enable;
  assign wake_input_flag = wif_r;
  assign bus_wake_flag = bif_r;
  assign wake_input_wake_flag = wwf_r;
  assign bus_wake_reset_flag = bwf_r;
  assign watchdog_reset_flag = wdf_r;
endmodule

// >>> tb/admc_assertions.sv
/* checker of the mode controller outputs.
   assumes one clock, bound to the controller. */
`timescale 1ns/1ps
module admc_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] mode,
  input wire logic watchdog_run,
  input wire logic watchdog_timeout,
  input wire logic reset_line_oe,
  input wire logic irq_line_oe,
  input wire logic irq_enables_clear,
  input wire logic spi_regs_reset,
  input wire logic logic_supply_on,
  input wire logic supply_limited,
  input wire logic power_stages_enable,
  input wire logic bus_tx_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence irq_8;
    irq_line_oe [*8];
  endsequence
  a_reset_pin_low: assert property (mode == 3'h0 |-> reset_line_oe && !power_stages_enable)
    else $error("reset state outputs");
  a_request_idle: assert property (mode == 3'h1 |-> !reset_line_oe && !bus_tx_enable
    && !power_stages_enable) else $error("request state outputs");
  a_normal_active: assert property (mode == 3'h2 |-> power_stages_enable && bus_tx_enable)
    else $error("normal state outputs");
  a_stop_quiet: assert property (mode == 3'h3 |-> supply_limited && !reset_line_oe
    && logic_supply_on && !power_stages_enable && !watchdog_run && !bus_tx_enable)
    else $error("stop state outputs");
  a_sleep_off: assert property (mode == 3'h4 |-> !logic_supply_on && reset_line_oe
    && !bus_tx_enable) else $error("sleep state outputs");
  a_regs_clear: assert property (mode == 3'h0 |-> spi_regs_reset && irq_enables_clear)
    else $error("clears missing in reset");
  a_irq_pulse: assert property ($rose(irq_line_oe) |-> irq_8 ##1 irq_8 ##1 !irq_line_oe)
    else $error("irq pulse length");
  a_dog_reset: assert property (watchdog_run && watchdog_timeout |-> ##[1:3] mode == 3'h0)
    else $error("no watchdog reset");
endmodule
bind admc_mode_ctrl admc_assertions admc_assertions_inst (.clk, .arst_n, .mode, .watchdog_run,
  .watchdog_timeout, .reset_line_oe, .irq_line_oe, .irq_enables_clear, .spi_regs_reset,
  .logic_supply_on, .supply_limited, .power_stages_enable, .bus_tx_enable);

// >>> tb/admc_mcu_model.sv
/* model of the embedded controller writing its control bits.
   assumes the mode output on the same clock. */
`timescale 1ns/1ps
module admc_mcu_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] mode,
  input wire logic go_stop,
  input wire logic go_sleep,
  input wire logic late,
  output logic stop_bit,
  output logic sleep_bit,
  output logic power_stage_on_bit
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_bit <= 1'h0;
      sleep_bit <= 1'h0;
      power_stage_on_bit <= 1'h0;
    end else if (mode == 3'h0 || mode == 3'h4) begin
      stop_bit <= 1'h0;
      sleep_bit <= 1'h0;
      power_stage_on_bit <= 1'h0;
    end else begin
      if (mode == 3'h1 && !late) power_stage_on_bit <= 1'h1;
      stop_bit <= go_stop && mode == 3'h2;
      sleep_bit <= go_sleep && mode == 3'h2;
    end
  end
endmodule

// >>> tb/analog_die_mode_controller_test.sv
/* self-checking bench of the mode controller.
   assumes the controller model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module analog_die_mode_controller_test;
  logic clk = 0, arst_n = 0, go_stop = 0, go_sleep = 0, late = 0;
  logic bus_wake_irq_enable = 0, wake_input_irq_enable = 0, watchdog_enable = 0;
  logic watchdog_timeout = 0, watchdog_bad_service = 0, flag_clear_wake_input = 0;
  logic flag_clear_bus_wake = 0, reset_flags_clear = 0, wake_up_input = 0;
  logic bus_wake_event = 0, factory_test_input = 0;
  logic stop_bit, sleep_bit, power_stage_on_bit, irq_line_oe, bus_rx_enable;
  logic wake_input_flag, bus_wake_flag, wake_input_wake_flag, bus_wake_reset_flag;
  logic watchdog_reset_flag;
  logic [2:0] mode;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  admc_mode_ctrl #(.WINDOW_CYC(50)) admc_mode_ctrl_inst (.clk, .arst_n, .stop_bit, .sleep_bit,
    .power_stage_on_bit, .bus_wake_irq_enable, .wake_input_irq_enable, .watchdog_enable,
    .watchdog_timeout, .watchdog_bad_service, .flag_clear_wake_input, .flag_clear_bus_wake,
    .reset_flags_clear, .wake_up_input, .bus_wake_event, .factory_test_input, .mode,
    .spi_regs_reset(), .irq_enables_clear(), .reset_line_o(), .reset_line_oe(), .irq_line_o(),
    .irq_line_oe, .logic_supply_on(), .supply_limited(), .power_stages_enable(),
    .bus_tx_enable(), .bus_rx_enable, .watchdog_run(), .wake_input_flag, .bus_wake_flag,
    .wake_input_wake_flag, .bus_wake_reset_flag, .watchdog_reset_flag);
  admc_mcu_model admc_mcu_model_inst (.clk, .arst_n, .mode, .go_stop, .go_sleep, .late,
    .stop_bit, .sleep_bit, .power_stage_on_bit);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 5000) begin
    fail_count++;
    wrap_up();
  end
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 300 && mode !== m; i++) @(negedge clk);
    `CHK("mode", m, mode)
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic t_stop;
    wake_input_irq_enable = 1;
    go_stop = 1;
    wait_mode(3'h3);
    go_stop = 0;
    bus_wake_event = 1;
    repeat (8) @(negedge clk);
    `CHK("masked", 3'h3, mode)
    wake_up_input = 1;
    wait_mode(3'h2);
    bus_wake_event = 0;
    `CHK("irq", 1'h1, irq_line_oe)
    `CHK("in flag", 1'h1, wake_input_flag)
    pulse(flag_clear_wake_input);
    `CHK("in clear", 1'h0, wake_input_flag)
    repeat (16) @(negedge clk);
    `CHK("irq end", 1'h0, irq_line_oe)
    bus_wake_irq_enable = 1;
    go_stop = 1;
    wait_mode(3'h3);
    go_stop = 0;
    `CHK("rx on", 1'h1, bus_rx_enable)
    bus_wake_event = 1;
    wait_mode(3'h2);
    bus_wake_event = 0;
    `CHK("bus flag", 1'h1, bus_wake_flag)
    `CHK("in quiet", 1'h0, wake_input_flag)
    pulse(flag_clear_bus_wake);
    `CHK("bus clear", 1'h0, bus_wake_flag)
  endtask
  task automatic t_sleep;
    // sleep wake must not depend on the stop-mode enables
    bus_wake_irq_enable = 0;
    wake_input_irq_enable = 0;
    go_sleep = 1;
    wait_mode(3'h4);
    go_sleep = 0;
    bus_wake_event = 1;
    wait_mode(3'h0);
    `CHK("bus wake", 1'h1, bus_wake_reset_flag)
    `CHK("in wake", 1'h0, wake_input_wake_flag)
    wait_mode(3'h1);
    wait_mode(3'h2);
  endtask
  task automatic t_dog;
    watchdog_enable = 1;
    @(negedge clk);
    pulse(watchdog_bad_service);
    wait_mode(3'h0);
    `CHK("dog flag", 1'h1, watchdog_reset_flag)
    `CHK("kept", 1'h1, bus_wake_reset_flag)
    wait_mode(3'h2);
  endtask
  task automatic t_deadline;
    late = 1;
    factory_test_input = 1;
    repeat (5) @(negedge clk);
    `CHK("rx test", 1'h0, bus_rx_enable)
    pulse(watchdog_timeout);
    wait_mode(3'h0);
    wait_mode(3'h1);
    repeat (120) @(negedge clk);
    `CHK("no deadline", 3'h1, mode)
    `CHK("rx off", 1'h0, bus_rx_enable)
    factory_test_input = 0;
    // deadline of 50 cycles starts two edges after the test level drops
    repeat (45) @(negedge clk);
    `CHK("early sleep", 3'h1, mode)
    repeat (10) @(negedge clk);
    `CHK("deadline", 3'h4, mode)
    wait_mode(3'h4);
    late = 0;
    wake_up_input = 0;
    wait_mode(3'h0);
    `CHK("in wake", 1'h1, wake_input_wake_flag)
    wait_mode(3'h2);
    pulse(reset_flags_clear);
    `CHK("src clear", 3'h0, {wake_input_wake_flag, bus_wake_reset_flag, watchdog_reset_flag})
  endtask
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1;
    wait_mode(3'h1);
    wait_mode(3'h2);
    t_stop;
    t_sleep;
    t_dog;
    t_deadline;
    wrap_up();
  end
endmodule
